// file: core/csb_device.sv
// Overview of operation
// (R1) Slave link, modes 0 and 3 only
// (R2) Host keeps serial clock at most half
// (R3) Output driven while enabled, else released
// (R4) First word after enable falls is command
// (R5) Enable rising aborts operation, awaits command
// (R6) Low 13 command bits are the address
// (R7) Opcode 1: single write, zeros out
// (R8) Opcode 2: single read, data third word
// (R9) Opcode 3: block write, rising addresses
// (R10) Opcode 4: block read, rising addresses
// (R11) Word count is 13 bits, max 8191
// (R12) Block ends at count or enable rise
// (R13) New command accepted without enable toggle
// (R14) Nonzero word in last read word is command
// (R15) Interpreter masters system bus, single or burst
// (R16) Bus addresses reach RAM and register sets
// (R17) Shares bus with DMA without blocking
// (R18) Shared memory holds 4 kB of samples
// (R19) All link items are 16-bit words
// (R20) Opcode on top three bits, MSB first
// (R21) Zeros on idle words, bad opcode ignored
`timescale 1ns/10ps
module csb_device (
	// System clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Serial link, clocked by the host
	csb_link_if.device link,
	// System bus master
	output logic sysbus_req_o,
	input wire logic sysbus_gnt_i,
	input wire logic sysbus_ack_i,
	output logic sysbus_we_o,
	output logic sysbus_burst_o,
	output logic [12:0] sysbus_addr_o,
	output logic [15:0] sysbus_wdata_o,
	input wire logic [15:0] sysbus_rdata_i,
	// Status
	output logic cmd_active_o
);
	logic link_rst_n;
	logic [3:0] bit_cnt;
	logic [14:0] rx_shift;
	logic [15:0] rx_word;
	logic rx_toggle;
	logic [15:0] tx_hold;
	logic [14:0] tx_shift;
	logic sdo;
	logic [15:0] tx_word;
	logic tog_s;
	logic tog_seen;
	logic en_s;
	logic evt;
	logic take_cmd;
	logic [2:0] cmd_op;
	logic [12:0] len_in;
	csb_pkg::csb_cmd_state_type state;
	logic [2:0] op;
	logic [12:0] addr;
	logic [12:0] count;
	logic acc_start;
	logic acc_we;
	logic acc_burst;
	logic [12:0] acc_addr;
	logic clear_tx;
	logic rd_done;

	// Enable high holds word framing in reset
	assign link_rst_n = reset_n_i & ~link.xfer_en_n; // see (R4) see (R5)

	// Bit counter and receive shifter, sampled on rising edge
	always_ff @(posedge link.serial_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			bit_cnt <= csb_pkg::BIT_FIRST;
			rx_shift <= 15'h0000;
			tx_hold <= csb_pkg::WORD_ZERO;
		end
		else
		begin
			bit_cnt <= bit_cnt + 4'h1; // see (R19)
			rx_shift <= {rx_shift[13:0], link.serial_data_in}; // see (R20)
			// Word for next slot taken on the last rising edge of the current word
			if (bit_cnt == csb_pkg::BIT_LAST)
				tx_hold <= tx_word;
		end
	end

	// Completed word and its toggle outlive the frame
	always_ff @(posedge link.serial_clk or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rx_word <= csb_pkg::WORD_ZERO;
			rx_toggle <= 1'b0;
		end
		else if (bit_cnt == csb_pkg::BIT_LAST)
		begin
			rx_word <= {rx_shift, link.serial_data_in}; // see (R19)
			rx_toggle <= ~rx_toggle;
		end
	end

	// Shift out on falling edge so data is stable at the rise
	always_ff @(negedge link.serial_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			sdo <= 1'b0;
			tx_shift <= 15'h0000;
		end
		else if (bit_cnt == csb_pkg::BIT_FIRST)
		begin
			sdo <= tx_hold[15]; // see (R1) see (R20)
			tx_shift <= tx_hold[14:0];
		end
		else
		begin
			sdo <= tx_shift[14];
			tx_shift <= {tx_shift[13:0], 1'b0};
		end
	end

	// Pin driver follows the enable without waiting for a clock
	assign link.serial_data_out = sdo;
	assign link.serial_data_out_oe = ~link.xfer_en_n; // see (R3)

	// Toggle and enable cross into the system domain
	csb_sync3 #(
		.RESET_VAL(1'b0)
	) u_tog_sync (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.async_i(rx_toggle),
		.level_o(tog_s)
	);

	csb_sync3 #(
		.RESET_VAL(1'b1)
	) u_en_sync (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.async_i(link.xfer_en_n),
		.level_o(en_s)
	);

	// Word events; rx_word is stable for a full word after the toggle
	assign evt = (tog_s != tog_seen) & ~en_s;
	assign cmd_op = rx_word[15:13]; // see (R20)
	assign len_in = rx_word[12:0]; // see (R11)
	assign take_cmd = evt & ((state == csb_pkg::ST_CMD) |
		((state == csb_pkg::ST_RDATA) & (count == csb_pkg::COUNT_ONE) &
		(|rx_word))); // see (R13) see (R14)

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			tog_seen <= 1'b0;
		else if (clk_en_i)
			tog_seen <= tog_s;
	end

	// Command interpreter
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= csb_pkg::ST_CMD;
			op <= 3'h0;
			addr <= csb_pkg::ADDR_ZERO;
			count <= csb_pkg::ADDR_ZERO;
		end
		else if (clk_en_i)
		begin
			if (en_s)
				state <= csb_pkg::ST_CMD; // see (R5) see (R12)
			else if (take_cmd)
			begin
				op <= cmd_op;
				addr <= rx_word[12:0]; // see (R6)
				unique case (cmd_op)
					csb_pkg::OP_WRITE: state <= csb_pkg::ST_WDATA; // see (R7)
					csb_pkg::OP_READ: state <= csb_pkg::ST_RDUMMY; // see (R8)
					csb_pkg::OP_BLOCK_WRITE,
					csb_pkg::OP_BLOCK_READ: state <= csb_pkg::ST_LEN;
					default: state <= csb_pkg::ST_IGNORE; // see (R21)
				endcase
			end
			else if (evt)
			begin
				unique case (state)
					csb_pkg::ST_LEN:
					begin
						count <= len_in; // see (R11)
						if (len_in == csb_pkg::ADDR_ZERO)
							state <= csb_pkg::ST_CMD;
						else if (op == csb_pkg::OP_BLOCK_WRITE)
							state <= csb_pkg::ST_WDATA; // see (R9)
						else
							state <= csb_pkg::ST_RDATA; // see (R10)
					end
					csb_pkg::ST_WDATA:
					begin
						addr <= addr + 13'h0001; // see (R9)
						count <= count - csb_pkg::COUNT_ONE;
						if (op == csb_pkg::OP_WRITE ||
							count == csb_pkg::COUNT_ONE)
							state <= csb_pkg::ST_CMD; // see (R12) see (R13)
					end
					csb_pkg::ST_RDUMMY:
					begin
						count <= csb_pkg::COUNT_ONE;
						state <= csb_pkg::ST_RDATA; // see (R8)
					end
					csb_pkg::ST_RDATA:
					begin
						addr <= addr + 13'h0001; // see (R10)
						count <= count - csb_pkg::COUNT_ONE;
						if (count == csb_pkg::COUNT_ONE)
							state <= csb_pkg::ST_CMD; // see (R12)
					end
					csb_pkg::ST_CMD,
					csb_pkg::ST_IGNORE:
						state <= state; // see (R21)
				endcase
			end
		end
	end

	// Bus access requests; reads are fetched one word ahead
	always_comb
	begin
		acc_start = 1'b0;
		acc_we = 1'b0;
		acc_addr = addr;
		acc_burst = (op == csb_pkg::OP_BLOCK_WRITE) |
			(op == csb_pkg::OP_BLOCK_READ);
		clear_tx = 1'b0;
		if (take_cmd)
		begin
			acc_start = (cmd_op == csb_pkg::OP_READ) |
				(cmd_op == csb_pkg::OP_BLOCK_READ); // see (R8) see (R10)
			acc_addr = rx_word[12:0];
			acc_burst = (cmd_op == csb_pkg::OP_BLOCK_READ);
		end
		else if (evt && state == csb_pkg::ST_WDATA)
		begin
			acc_start = 1'b1; // see (R7) see (R9)
			acc_we = 1'b1;
		end
		else if (evt && state == csb_pkg::ST_LEN &&
			op == csb_pkg::OP_BLOCK_READ)
		begin
			acc_start = (len_in > csb_pkg::COUNT_ONE);
			acc_addr = addr + 13'h0001;
			clear_tx = ~acc_start;
		end
		else if (evt && state == csb_pkg::ST_RDATA)
		begin
			acc_start = (count > csb_pkg::COUNT_TWO);
			acc_addr = addr + 13'h0002;
			clear_tx = ~acc_start;
		end
		else if (evt && state == csb_pkg::ST_RDUMMY)
			clear_tx = 1'b1; // see (R21)
	end

	// Master holds request until the arbiter grants and acknowledges
	assign rd_done = sysbus_req_o & sysbus_gnt_i & sysbus_ack_i &
		~sysbus_we_o;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sysbus_req_o <= 1'b0;
			sysbus_we_o <= 1'b0;
			sysbus_burst_o <= 1'b0;
			sysbus_addr_o <= csb_pkg::ADDR_ZERO;
			sysbus_wdata_o <= csb_pkg::WORD_ZERO;
		end
		else if (clk_en_i)
		begin
			if (acc_start)
			begin
				sysbus_req_o <= 1'b1; // see (R15) see (R16)
				sysbus_we_o <= acc_we;
				sysbus_burst_o <= acc_burst;
				sysbus_addr_o <= acc_addr;
				sysbus_wdata_o <= rx_word;
			end
			else if (sysbus_gnt_i && sysbus_ack_i)
				sysbus_req_o <= 1'b0; // see (R17)
		end
	end

	// Outgoing word: read data, else zeros; late data after abort dropped
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			tx_word <= csb_pkg::WORD_ZERO;
		else if (clk_en_i)
		begin
			if (en_s || clear_tx)
				tx_word <= csb_pkg::WORD_ZERO; // see (R7) see (R21)
			else if (rd_done)
				tx_word <= sysbus_rdata_i; // see (R8) see (R10)
		end
	end

	// Status flag
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			cmd_active_o <= 1'b0;
		else if (clk_en_i)
			cmd_active_o <= (state != csb_pkg::ST_CMD);
	end
endmodule // csb_device

// file: core/csb_host.sv
`timescale 1ns/10ps
module csb_host #(
	parameter int SCLK_HALF = csb_pkg::SCLK_HALF
) (
	// System clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Mode select: low for mode 0, high for mode 3
	input wire logic mode3_i,
	// Words to send
	input wire logic tx_valid_i,
	input wire logic [15:0] tx_word_i,
	input wire logic tx_last_i,
	output logic tx_ready_o,
	// Words received
	output logic rx_valid_o,
	output logic [15:0] rx_word_o,
	// Serial link, this end makes the clock
	csb_link_if.host link
);
	csb_pkg::csb_host_state_type state;
	logic [7:0] half_cnt;
	logic half_end;
	logic ph;
	logic [3:0] bit_idx;
	logic [15:0] tx_sh;
	logic [14:0] rx_sh;
	logic last;
	logic sclk;
	logic en_n;
	logic mosi;
	logic miso_s;

	// Returned data is a pin from another domain
	csb_sync3 #(
		.RESET_VAL(1'b1)
	) u_miso_sync (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.async_i(link.serial_data_line),
		.level_o(miso_s)
	);

	// Divider keeps the serial clock at most half the system clock
	assign half_end = (half_cnt == 8'(SCLK_HALF - 1)); // see (R2)

	assign link.serial_clk = sclk;
	assign link.xfer_en_n = en_n;
	assign link.serial_data_in = mosi;

	// Frame sequencer; idle clock level selects the mode
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= csb_pkg::H_IDLE;
			half_cnt <= 8'h00;
			ph <= 1'b0;
			bit_idx <= csb_pkg::BIT_FIRST;
			tx_sh <= csb_pkg::WORD_ZERO;
			rx_sh <= 15'h0000;
			last <= 1'b0;
			sclk <= 1'b0;
			en_n <= 1'b1;
			mosi <= 1'b0;
			tx_ready_o <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_word_o <= csb_pkg::WORD_ZERO;
		end
		else if (clk_en_i)
		begin
			tx_ready_o <= 1'b0;
			rx_valid_o <= 1'b0;
			unique case (state)
				csb_pkg::H_IDLE:
				begin
					sclk <= mode3_i; // see (R1)
					if (tx_valid_i)
					begin
						// Mode 3 needs a leading fall before the first rise
						sclk <= 1'b0; // see (R1)
						en_n <= 1'b0;
						tx_sh <= {tx_word_i[14:0], 1'b0};
						mosi <= tx_word_i[15]; // see (R20)
						last <= tx_last_i;
						tx_ready_o <= 1'b1;
						bit_idx <= csb_pkg::BIT_FIRST;
						ph <= 1'b0;
						half_cnt <= 8'h00;
						state <= csb_pkg::H_SHIFT;
					end
				end
				csb_pkg::H_SHIFT:
				begin
					half_cnt <= half_cnt + 8'h01;
					if (half_end)
					begin
						half_cnt <= 8'h00;
						if (!ph)
						begin
							// Rising edge: device samples mosi
							ph <= 1'b1;
							sclk <= 1'b1;
						end
						else if (bit_idx != csb_pkg::BIT_LAST)
						begin
							// Sampled late in high half, then fall
							rx_sh <= {rx_sh[13:0], miso_s};
							ph <= 1'b0;
							sclk <= 1'b0;
							mosi <= tx_sh[15];
							tx_sh <= {tx_sh[14:0], 1'b0};
							bit_idx <= bit_idx + 4'h1;
						end
						else
						begin
							rx_word_o <= {rx_sh, miso_s}; // see (R19)
							rx_valid_o <= 1'b1;
							sclk <= mode3_i;
							state <= last ? csb_pkg::H_GAP : csb_pkg::H_IDLE;
						end
					end
				end
				csb_pkg::H_GAP:
				begin
					half_cnt <= half_cnt + 8'h01;
					if (half_end)
					begin
						half_cnt <= 8'h00;
						en_n <= 1'b1;
						state <= csb_pkg::H_HIGH;
					end
				end
				csb_pkg::H_HIGH:
				begin
					half_cnt <= half_cnt + 8'h01;
					if (half_end)
					begin
						half_cnt <= 8'h00;
						state <= csb_pkg::H_IDLE;
					end
				end
			endcase
		end
	end
endmodule // csb_host

// file: core/csb_link_if.sv
`timescale 1ns/10ps
interface csb_link_if;
	logic serial_clk;
	logic xfer_en_n;
	logic serial_data_in;
	logic serial_data_out;
	logic serial_data_out_oe;
	logic serial_data_line;

	// Undriven line modelled as pulled high
	assign serial_data_line = serial_data_out_oe ? serial_data_out : 1'b1;

	modport device (
		input serial_clk,
		input xfer_en_n,
		input serial_data_in,
		output serial_data_out,
		output serial_data_out_oe
	);

	modport host (
		output serial_clk,
		output xfer_en_n,
		output serial_data_in,
		input serial_data_line
	);
endinterface

// file: core/csb_pkg.sv
package csb_pkg;
	// Word framing on the serial link
	localparam int WORD_W = 16;
	localparam int ADDR_W = 13;
	localparam int OP_W = 3;
	localparam int OP_LSB = 13;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'hF;

	// Opcodes in the top three bits of a command word
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_READ = 3'h2;
	localparam logic [2:0] OP_BLOCK_WRITE = 3'h3;
	localparam logic [2:0] OP_BLOCK_READ = 3'h4;

	// Block length limits and shared sample memory size
	localparam logic [12:0] COUNT_ONE = 13'h0001;
	localparam logic [12:0] COUNT_TWO = 13'h0002;
	localparam logic [12:0] COUNT_MAX = 13'h1FFF;
	localparam int RAM_BYTES = 4096;

	// Host clock divider: half serial period in system cycles
	localparam int SCLK_HALF = 4;

	// Reset values
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [12:0] ADDR_ZERO = 13'h0000;

	typedef enum logic [2:0] {
		ST_CMD = 3'b000,
		ST_LEN = 3'b001,
		ST_WDATA = 3'b010,
		ST_RDUMMY = 3'b011,
		ST_RDATA = 3'b100,
		ST_IGNORE = 3'b101
	} csb_cmd_state_type;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SHIFT = 2'b01,
		H_GAP = 2'b10,
		H_HIGH = 2'b11
	} csb_host_state_type;

	// Command word: opcode above the address
	function automatic logic [15:0] make_cmd(input logic [2:0] op,
		input logic [12:0] addr);
		return {op, addr};
	endfunction
endpackage

// file: core/csb_sync3.sv
`timescale 1ns/10ps
module csb_sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Foreign level in, filtered level out
	input wire logic async_i,
	output logic level_o
);
	logic s1;
	logic s2;
	logic s3;

	// Three stages; only the last two are compared
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
			level_o <= RESET_VAL;
		end
		else if (clk_en_i)
		begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level_o <= s3;
		end
	end
endmodule // csb_sync3

// file: verif/csb_link_checker.sv
`timescale 1ns/10ps
// Watches the link between the two ends, sampled on the system clock
module csb_link_checker (
	// System clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Link signals
	input wire logic serial_clk,
	input wire logic xfer_en_n,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe,
	input wire logic serial_data_line
);
	logic sclk_q;
	logic [3:0] rise_cnt;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	// Previous link clock level for edge detection
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			sclk_q <= 1'b0;
		else
			sclk_q <= serial_clk;
	end

	// Rises in the frame, modulo one word
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rise_cnt <= 4'h0;
		else if (xfer_en_n)
			rise_cnt <= 4'h0;
		else if (serial_clk && !sclk_q)
			rise_cnt <= rise_cnt + 4'h1;
	end

	property p_oe_tracks_en;
		serial_data_out_oe == !xfer_en_n;
	endproperty
	a_oe_tracks_en: assert property (p_oe_tracks_en)
		else $error("output enable not tracking enable");

	property p_line_released;
		xfer_en_n |-> serial_data_line;
	endproperty
	a_line_released: assert property (p_line_released)
		else $error("data line driven while disabled");

	property p_sclk_high;
		$rose(serial_clk) |-> serial_clk [*4];
	endproperty
	a_sclk_high: assert property (p_sclk_high)
		else $error("link clock high phase too short");

	property p_sclk_low;
		$fell(serial_clk) && !xfer_en_n |-> !serial_clk [*4];
	endproperty
	a_sclk_low: assert property (p_sclk_low)
		else $error("link clock low phase too short");

	property p_din_steady;
		$rose(serial_clk) && !xfer_en_n |->
			$stable(serial_data_in) ##1 $stable(serial_data_in);
	endproperty
	a_din_steady: assert property (p_din_steady)
		else $error("input data moved at sampling edge");

	property p_dout_on_fall;
		!xfer_en_n && !$past(xfer_en_n) && $changed(serial_data_out)
			|-> $fell(serial_clk);
	endproperty
	a_dout_on_fall: assert property (p_dout_on_fall)
		else $error("output data moved off falling edge");

	property p_en_high_hold;
		$rose(xfer_en_n) |-> xfer_en_n [*8];
	endproperty
	a_en_high_hold: assert property (p_en_high_hold)
		else $error("enable high phase too short");

	property p_whole_words;
		$rose(xfer_en_n) |-> rise_cnt == 4'h0;
	endproperty
	a_whole_words: assert property (p_whole_words)
		else $error("frame ended inside a word");

	property p_cmd_zeros;
		$fell(xfer_en_n) |-> !serial_data_out [*8];
	endproperty
	a_cmd_zeros: assert property (p_cmd_zeros)
		else $error("output not zero in command word");
endmodule // csb_link_checker

// file: verif/tb_codec_spi_command_bus_master.sv
`timescale 1ns/10ps
module tb_codec_spi_command_bus_master;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic mode3_i = 1'b0;
	logic tx_valid_i = 1'b0;
	logic tx_last_i = 1'b0;
	logic [15:0] tx_word_i = 16'h0000;
	logic tx_ready_o, rx_valid_o, sysbus_req_o, sysbus_we_o;
	logic sysbus_burst_o, cmd_active_o;
	logic [15:0] rx_word_o, sysbus_wdata_o;
	logic [12:0] sysbus_addr_o;
	logic sysbus_gnt_i = 1'b0;
	logic sysbus_ack_i = 1'b0;
	logic [15:0] sysbus_rdata_i = 16'h0000;
	logic [15:0] mem [0:8191];
	logic [15:0] ref_mem [0:8191];
	logic [30:0] q_bus [$];
	logic [15:0] q_rx [$];
	logic [15:0] fw [$];
	logic [15:0] fe [$];
	int n_errors = 0;
	int n_checks = 0;
	int seed = 30183;
	int cycles = 0;

	csb_link_if link();
	csb_host i_csb_host (.clk_sys_i, .reset_n_i, .clk_en_i, .mode3_i,
		.tx_valid_i, .tx_word_i, .tx_last_i, .tx_ready_o, .rx_valid_o,
		.rx_word_o, .link(link));
	csb_device i_csb_device (.clk_sys_i, .reset_n_i, .clk_en_i,
		.link(link), .sysbus_req_o, .sysbus_gnt_i, .sysbus_ack_i,
		.sysbus_we_o, .sysbus_burst_o, .sysbus_addr_o, .sysbus_wdata_o,
		.sysbus_rdata_i, .cmd_active_o);
	csb_link_checker i_csb_link_checker (.clk_sys_i, .reset_n_i,
		.serial_clk(link.serial_clk), .xfer_en_n(link.xfer_en_n),
		.serial_data_in(link.serial_data_in),
		.serial_data_out(link.serial_data_out),
		.serial_data_out_oe(link.serial_data_out_oe),
		.serial_data_line(link.serial_data_line));

	always #10 clk_sys_i = ~clk_sys_i;

	task automatic end_sim();
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp_rx(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %0t rx %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_bus(input logic [30:0] g, input logic [30:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %0t bus %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_flag(input logic g, input logic e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %0t flag %b exp %b", $time, g, e);
		end
	endtask

	// Host side: each received word against the oldest note
	always @(posedge clk_sys_i)
	begin
		if (rx_valid_o === 1'b1)
			cmp_rx(rx_word_o, q_rx.size() ? q_rx.pop_front() : 16'hXXXX);
	end

	// Sample memory; random grant gaps stand in for the DMA owning the bus
	always @(posedge clk_sys_i)
	begin
		if (sysbus_req_o === 1'b1 && sysbus_gnt_i && sysbus_ack_i)
		begin
			cmp_bus({sysbus_we_o, sysbus_burst_o, sysbus_addr_o,
				sysbus_we_o ? sysbus_wdata_o : 16'h0000},
				q_bus.size() ? q_bus.pop_front() : 31'h7FFFFFFF);
			if (sysbus_we_o)
				mem[sysbus_addr_o] = sysbus_wdata_o;
		end
		sysbus_gnt_i <= ($random(seed) & 3) != 0;
		sysbus_ack_i <= sysbus_req_o && !sysbus_ack_i && $random(seed) % 2;
		sysbus_rdata_i <= mem[sysbus_addr_o];
	end

	// Hang guard, well above the expected run length
	always @(posedge clk_sys_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			n_errors++;
			end_sim();
		end
	end

	// One word of the next frame and the word the host should get back
	task automatic put(input logic [15:0] w, input logic [15:0] e);
		fw.push_back(w);
		fe.push_back(e);
	endtask

	// One expected bus access; writes also update the reference copy
	task automatic acc(input logic we, input logic bu, input logic [12:0] a,
		input logic [15:0] d);
		q_bus.push_back({we, bu, a, we ? d : 16'h0000});
		if (we)
			ref_mem[a] = d;
	endtask

	// Sends the queued frame in a random mode; enable rises after it
	task automatic run_frame();
		int i;
		mode3_i <= $random(seed) % 2 != 0;
		repeat (8) @(posedge clk_sys_i);
		for (i = 0; i < fw.size(); i++)
		begin
			q_rx.push_back(fe[i]);
			tx_word_i <= fw[i];
			tx_last_i <= i == fw.size() - 1;
			tx_valid_i <= 1'b1;
			@(posedge clk_sys_i);
			while (tx_ready_o !== 1'b1)
				@(posedge clk_sys_i);
		end
		tx_valid_i <= 1'b0;
		fw.delete();
		fe.delete();
		repeat (200) @(posedge clk_sys_i);
		cmp_flag(cmd_active_o, 1'b0);
	endtask

	initial
	begin
		logic [12:0] a;
		logic [12:0] c;
		logic [15:0] d;
		int k;
		int j;
		repeat (6) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		for (k = 0; k < 3; k++)
		begin
			a = 13'($random(seed));
			c = a & 13'h1FF0;
			d = 16'($random(seed));
			// Write, read with a new command in its last word, chained
			put({3'h1, a}, 16'h0000);
			put(d, 16'h0000);
			acc(1'b1, 1'b0, a, d);
			put({3'h2, a}, 16'h0000);
			put(16'h0000, 16'h0000);
			acc(1'b0, 1'b0, a, 16'h0000);
			put({3'h1, a + 13'h0001}, d);
			d = 16'($random(seed));
			put(d, 16'h0000);
			acc(1'b1, 1'b0, a + 13'h0001, d);
			// Block write, count taken from the low 13 bits only
			put({3'h3, c}, 16'h0000);
			put(16'hE003, 16'h0000);
			for (j = 0; j < 3; j++)
			begin
				d = 16'($random(seed));
				put(d, 16'h0000);
				acc(1'b1, 1'b1, c + 13'(j), d);
			end
			// Block read of the same words
			put({3'h4, c}, 16'h0000);
			put(16'h0003, 16'h0000);
			for (j = 0; j < 3; j++)
			begin
				acc(1'b0, 1'b1, c + 13'(j), 16'h0000);
				put(16'h0000, ref_mem[c + 13'(j)]);
			end
			run_frame();
			// Block write cut short by the enable
			put({3'h3, c}, 16'h0000);
			put(16'h0005, 16'h0000);
			for (j = 0; j < 2; j++)
			begin
				d = 16'($random(seed));
				put(d, 16'h0000);
				acc(1'b1, 1'b1, c + 13'(j), d);
			end
			run_frame();
			// Undefined opcodes: no access, zeros out
			for (j = 4; j < 8; j++)
			begin
				put({j == 4 ? 3'h0 : 3'(j), a}, 16'h0000);
				put(16'($random(seed)), 16'h0000);
				run_frame();
			end
			// Word past the aborted block is untouched
			put({3'h2, c + 13'h0002}, 16'h0000);
			put(16'h0000, 16'h0000);
			acc(1'b0, 1'b0, c + 13'h0002, 16'h0000);
			put(16'h0000, ref_mem[c + 13'h0002]);
			run_frame();
		end
		cmp_flag(q_bus.size() == 0 && q_rx.size() == 0, 1'b1);
		end_sim();
	end
endmodule // tb_codec_spi_command_bus_master
